// ### hdl/pmsr_regs.sv
// Sequencer control and link status registers of the management slave
// Operation
// - Reset acts while reset level held
// - Read and write strobes active high
// - Hold request steady while wait asserted
// - Word address, 8-bit bus, 32-bit data
// - Unspecified registers and fields reset zero
// - Sequencer reset bit self clears
// - Bit 2 disables link fault timer
// - Bits 6:4 select forced protocol
// - Force applies only with sequencer reset
// - Force allows speed change if autodetect
// - Status bit 0 shows link ready
`timescale 1ns/1ns
`include "pmsr_map.svh"
module pmsr_regs #(
   parameter bit AUTO_SPEED_DETECT = 1'b1,
   parameter int RESET_PULSE_CYCLES = 1
) (
   // Clock, reset and enable
   input  wire logic                    i_clock,
   input  wire logic                    i_reset_n,
   input  wire logic                    i_clock_enable,
   // Management request
   input  wire pmsr_pkg::pmsr_req_t     i_mgmt_req,
   // Management answer
   output logic [31:0]                  o_mgmt_readdata,
   output logic                         o_mgmt_waitrequest,
   // Sequencer side
   input  wire logic                    i_sequencer_link_ready,
   output pmsr_pkg::pmsr_seq_ctrl_t     o_seq_ctrl
);
   import pmsr_pkg::*;

   // Handshake state, high in the completion cycle
   logic        busy_r;
   // Link ready after the two-flop synchroniser
   logic        link_ready_s;
   // Stored control fields
   logic        lft_dis_r;
   logic [2:0]  fps_r;
   // Sequencer reset pulse counter
   logic [3:0]  rst_cnt_r;
   // Address decode
   logic        hit_ctrl;
   logic        hit_stat;
   // Request qualifiers
   logic        req_any;
   logic        wr_go;
   logic        rd_go;
   logic        wr_ctrl;
   logic        seq_rst_req;
   logic        force_go;
   // Forced protocol field checks
   logic        fps_ok;
   logic [2:0]  wr_fps;
   logic [2:0]  force_code;
   // Read path
   logic [31:0] rd_mux;

   // Pulse length must fit the four-bit counter
   initial begin
      if (RESET_PULSE_CYCLES < 1 || RESET_PULSE_CYCLES > 15) begin
         $error("pmsr_regs: RESET_PULSE_CYCLES must be 1..15");
      end
   end

   // Link ready comes from the sequencer domain
   pmsr_sync #(
      .WIDTH (1)
   ) u_link_sync (
      .i_clock   (i_clock),
      .i_reset_n (i_reset_n),
      .i_enable  (i_clock_enable),
      .i_async   (i_sequencer_link_ready),
      .o_sync    (link_ready_s)
   );

   // Decode and strobes
   assign hit_ctrl = (i_mgmt_req.addr == `PMSR_OFS_SEQ_CTRL);
   assign hit_stat = (i_mgmt_req.addr == `PMSR_OFS_SEQ_STAT);
   // Any strobe starts a transfer
   assign req_any  = i_mgmt_req.write || i_mgmt_req.read;
   // One wait cycle, then complete while request held
   assign wr_go    = i_mgmt_req.write && busy_r;
   // Read data sampled at the taking edge
   assign rd_go    = i_mgmt_req.read && !i_mgmt_req.write &&
                     !busy_r;
   // Completed write to the control register
   assign wr_ctrl  = wr_go && hit_ctrl;
   // Sequencer reset requested by this write
   assign seq_rst_req = wr_ctrl &&
                        i_mgmt_req.wdata[`PMSR_BIT_SEQ_RST];
   // Force only applies with a reset and speed detection
   assign force_go = seq_rst_req && AUTO_SPEED_DETECT;

   // Forced protocol field and its legality
   assign wr_fps   = i_mgmt_req.wdata[`PMSR_FPS_MSB:`PMSR_FPS_LSB];
   assign fps_ok   = (wr_fps == `PMSR_FPS_NONE) ||
                     (wr_fps == `PMSR_FPS_GIGE) ||
                     (wr_fps == `PMSR_FPS_TENG);
   // Reserved codes fall back to the stored field
   assign force_code = fps_ok ? wr_fps : fps_r;

   // Read multiplexer, reserved bits zero
   always_comb begin
      rd_mux = `PMSR_ZERO32;
      if (hit_ctrl) begin
         rd_mux[`PMSR_BIT_LFT_DIS] = lft_dis_r;
         rd_mux[`PMSR_FPS_MSB:`PMSR_FPS_LSB] = fps_r;
      end else if (hit_stat) begin
         rd_mux[`PMSR_BIT_LINK_RDY] = link_ready_s;
      end
   end

   // Wait-request handshake
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         busy_r             <= 1'b0;
         o_mgmt_waitrequest <= 1'b1;
      end else if (i_clock_enable) begin
         if (busy_r) begin
            busy_r             <= 1'b0;
            o_mgmt_waitrequest <= 1'b1;
         end else if (req_any) begin
            busy_r             <= 1'b1;
            o_mgmt_waitrequest <= 1'b0;
         end else begin
            o_mgmt_waitrequest <= 1'b1;
         end
      end
   end

   // Read data captured at the taking edge
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         o_mgmt_readdata <= `PMSR_ZERO32;
      end else if (i_clock_enable) begin
         // Stands through the cycle with wait low
         if (rd_go) begin
            o_mgmt_readdata <= rd_mux;
         end
      end
   end

   // Control register fields
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         lft_dis_r <= 1'b0;
         fps_r     <= `PMSR_FPS_NONE;
      end else if (i_clock_enable && wr_ctrl) begin
         lft_dis_r <= i_mgmt_req.wdata[`PMSR_BIT_LFT_DIS];
         // Reserved codes are not stored
         if (fps_ok) begin
            fps_r <= wr_fps;
         end
      end
   end

   // Self-clearing sequencer reset pulse
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         rst_cnt_r <= 4'h0;
      end else if (i_clock_enable) begin
         // A new request reloads a running pulse
         if (seq_rst_req) begin
            rst_cnt_r <= 4'(RESET_PULSE_CYCLES);
         end else if (rst_cnt_r != 4'h0) begin
            rst_cnt_r <= rst_cnt_r - `PMSR_RST_PULSE;
         end
      end
   end

   // Outputs toward the sequencer
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         o_seq_ctrl <= '0;
      end else if (i_clock_enable) begin
         o_seq_ctrl.lf_timer_disable <= lft_dis_r;
         o_seq_ctrl.seq_reset <= (rst_cnt_r != 4'h0);
         // Force latched only together with a sequencer reset
         if (force_go) begin
            o_seq_ctrl.forced_protocol <= force_code;
            o_seq_ctrl.force_valid <= 1'b1;
         end
      end
   end
endmodule

// ### hdl/pmsr_map.svh
// Register offsets, field positions and reset values of the sequencer regs
`ifndef PMSR_MAP_SVH
`define PMSR_MAP_SVH
`define PMSR_ADDR_W        8
`define PMSR_DATA_W        32
`define PMSR_OFS_SEQ_CTRL  8'hB0
`define PMSR_OFS_SEQ_STAT  8'hB1
`define PMSR_BIT_SEQ_RST   0
`define PMSR_BIT_LFT_DIS   2
`define PMSR_FPS_LSB       4
`define PMSR_FPS_MSB       6
`define PMSR_BIT_LINK_RDY  0
`define PMSR_FPS_NONE      3'h0
`define PMSR_FPS_GIGE      3'h1
`define PMSR_FPS_TENG      3'h4
`define PMSR_ZERO32        32'h0
`define PMSR_RST_PULSE     4'h1
`endif

// ### hdl/pmsr_pkg.sv
// Types shared by the sequencer register bank
package pmsr_pkg;
   typedef enum logic [2:0] {
      PMSR_PROTO_NONE  = 3'h0,
      PMSR_PROTO_GIGE  = 3'h1,
      PMSR_PROTO_TENG  = 3'h4
   } pmsr_proto_t;

   // Management bus request from the master
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        write;
      logic        read;
   } pmsr_req_t;

   // Controls driven toward the sequencer
   typedef struct packed {
      logic        seq_reset;
      logic        lf_timer_disable;
      logic [2:0]  forced_protocol;
      logic        force_valid;
   } pmsr_seq_ctrl_t;
endpackage

// ### hdl/pmsr_sync.sv
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ns
module pmsr_sync #(
   parameter int WIDTH = 1
) (
   // Clock and control
   input  wire logic             i_clock,
   input  wire logic             i_reset_n,
   input  wire logic             i_enable,
   // Data
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_r;

   initial begin
      if (WIDTH < 1) begin
         $error("pmsr_sync: WIDTH must be at least 1");
      end
   end

   // First stage read only by the second
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         meta_r <= '0;
         o_sync <= '0;
      end else if (i_enable) begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end
endmodule

// ### sim/pmsr_regs_asserts.sv
// Port assertions for the sequencer register bank
`timescale 1ns/1ns
module pmsr_regs_asserts (
   // Watched ports
   input wire logic                     i_clock,
   input wire logic                     i_reset_n,
   input wire logic                     i_clock_enable,
   input wire pmsr_pkg::pmsr_req_t      i_mgmt_req,
   input wire logic [31:0]              o_mgmt_readdata,
   input wire logic                     o_mgmt_waitrequest,
   input wire pmsr_pkg::pmsr_seq_ctrl_t o_seq_ctrl
);
   import pmsr_pkg::*;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   // Any request strobe; taken while wait is high
   wire req = i_mgmt_req.read | i_mgmt_req.write;
   sequence s_take;
      req && o_mgmt_waitrequest && i_clock_enable;
   endsequence
   sequence s_wr_ctrl;
      i_mgmt_req.write && i_mgmt_req.addr == 8'hB0 ##0 s_take
         ##1 !o_mgmt_waitrequest;
   endsequence
   sequence s_rd_stat;
      i_mgmt_req.read && !i_mgmt_req.write && i_mgmt_req.addr == 8'hB1
         ##0 s_take ##1 !o_mgmt_waitrequest;
   endsequence
   a_reset_idle: assert property (disable iff (1'b0) !i_reset_n |=>
      o_mgmt_waitrequest && o_seq_ctrl == '0 && o_mgmt_readdata == 32'h0)
      else $error("reset state wrong");
   a_wait_answer: assert property (s_take |=> !o_mgmt_waitrequest)
      else $error("no answer");
   a_wait_one: assert property (!o_mgmt_waitrequest && i_clock_enable
      |=> o_mgmt_waitrequest) else $error("wait low too long");
   a_no_spurious: assert property (!req && o_mgmt_waitrequest
      |=> o_mgmt_waitrequest) else $error("answer without request");
   a_stat_upper: assert property (s_rd_stat
      |-> o_mgmt_readdata[31:1] == 31'h0) else $error("status upper bits");
   a_seq_pulse: assert property (s_wr_ctrl ##0 $past(i_mgmt_req.wdata[0])
      |-> ##2 o_seq_ctrl.seq_reset) else $error("no sequencer reset");
   a_lft_follow: assert property (s_wr_ctrl |-> ##2
      o_seq_ctrl.lf_timer_disable == $past(i_mgmt_req.wdata[2], 3))
      else $error("timer disable wrong");
   a_code_legal: assert property (o_seq_ctrl.forced_protocol
      inside {3'h0, 3'h1, 3'h4}) else $error("reserved code out");
endmodule
bind pmsr_regs pmsr_regs_asserts u_chk (.i_clock(i_clock),
   .i_reset_n(i_reset_n), .i_clock_enable(i_clock_enable),
   .i_mgmt_req(i_mgmt_req), .o_mgmt_readdata(o_mgmt_readdata),
   .o_mgmt_waitrequest(o_mgmt_waitrequest), .o_seq_ctrl(o_seq_ctrl));

// ### sim/pmsr_master.sv
// Bus master model issuing management reads and writes
`timescale 1ns/1ns
module pmsr_master (
   // Clock and answer
   input  wire logic           i_clock,
   input  wire logic           i_waitrequest,
   input  wire logic [31:0]    i_readdata,
   // Request
   output pmsr_pkg::pmsr_req_t o_req
);
   import pmsr_pkg::*;
   initial o_req = '0;
   // One transfer, any address, held until wait drops or 20 cycles pass
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q);
      @(negedge i_clock);
      o_req = '{addr: a, wdata: d, write: w, read: !w};
      for (int n = 0; n < 20 && i_waitrequest !== 1'b0; n++)
         @(negedge i_clock);
      // A hung transfer hands back unknown data
      q = (i_waitrequest === 1'b0) ? i_readdata : 32'hx;
      @(negedge i_clock);
      o_req = '{addr: ~a, wdata: ~d, write: 1'b0, read: 1'b0};
   endtask
endmodule

// ### sim/testbench.sv
// Self-checking bench for the sequencer register bank
`timescale 1ns/1ns
module testbench;
   import pmsr_pkg::*;
   logic           i_clock = 1'b0;
   logic           i_reset_n = 1'b0;
   logic           link = 1'b0;
   logic           en = 1'b1;
   logic           wait_req;
   logic [31:0]    rdata;
   logic [31:0]    q;
   pmsr_req_t      req;
   pmsr_seq_ctrl_t ctrl;
   int             fail_count = 0;
   int             n_checks = 0;
   // Clock
   initial forever #5 i_clock = ~i_clock;
   pmsr_master u_mst (.i_clock(i_clock), .i_waitrequest(wait_req),
      .i_readdata(rdata), .o_req(req));
   pmsr_regs i_dut (.i_clock(i_clock), .i_reset_n(i_reset_n),
      .i_clock_enable(en), .i_mgmt_req(req), .o_mgmt_readdata(rdata),
      .o_mgmt_waitrequest(wait_req), .i_sequencer_link_ready(link),
      .o_seq_ctrl(ctrl));
   task automatic check(input string what, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic t_reset();
      check("waitrequest", wait_req, 32'h1);
      check("seq ctrl", 32'(ctrl), 32'h0);
      u_mst.xfer(1'b0, 8'hB0, 32'h0, q);
      check("ctrl reset", q, 32'h0);
      $display("t_reset done");
   endtask
   task automatic t_ctrl();
      logic [31:0] wr [3] = '{32'hFFFF_FF8E, 32'h41, 32'h31};
      logic [31:0] rd [3] = '{32'h4, 32'h40, 32'h40};
      u_mst.xfer(1'b0, 8'hB0, 32'h0, q);
      u_mst.xfer(1'b1, 8'hB0, q | 32'h15, q);
      @(negedge i_clock);
      check("pulse", 32'(ctrl), 32'h33);
      @(negedge i_clock);
      check("self clear", 32'(ctrl), 32'h13);
      u_mst.xfer(1'b0, 8'hB0, 32'h0, q);
      check("ctrl readback", q, 32'h14);
      for (int i = 0; i < 3; i++) begin
         u_mst.xfer(1'b1, 8'hB0, wr[i], q);
         u_mst.xfer(1'b0, 8'hB0, 32'h0, q);
         check("ctrl field", q, rd[i]);
      end
      $display("t_ctrl done");
   endtask
   task automatic t_link();
      // Enable low: synchroniser must not advance
      en = 1'b0;
      link = 1'b1;
      repeat (4) @(negedge i_clock);
      check("frozen wait", wait_req, 32'h1);
      en = 1'b1;
      u_mst.xfer(1'b0, 8'hB1, 32'h0, q);
      check("frozen sync", q, 32'h0);
      repeat (4) @(negedge i_clock);
      u_mst.xfer(1'b0, 8'hB1, 32'h0, q);
      check("link ready", q, 32'h1);
      u_mst.xfer(1'b0, 8'h10, 32'h0, q);
      check("unmapped", q, 32'h0);
      link = 1'b0;
      repeat (4) @(negedge i_clock);
      u_mst.xfer(1'b0, 8'hB1, 32'h0, q);
      check("link low", q, 32'h0);
      $display("t_link done");
   endtask
   // Main sequence
   initial begin
      repeat (3) @(negedge i_clock);
      i_reset_n = 1'b1;
      t_reset();
      t_ctrl();
      t_link();
      summarize();
   end
   // Watchdog
   initial begin
      repeat (2000) @(negedge i_clock);
      fail_count++;
      summarize();
   end
endmodule
